// ===== rtl/spmsp_pkg.sv
// Register map, field positions, rate table and pin bundles of the serial port
package spmsp_pkg;

    localparam int unsigned ADDR_W = 2;
    localparam int unsigned DATA_W = 8;

    localparam logic [ADDR_W-1:0] OFF_DATA = 2'h0;
    localparam logic [ADDR_W-1:0] OFF_CTRL = 2'h1;
    localparam logic [ADDR_W-1:0] OFF_STAT = 2'h2;

    // Control register fields
    localparam int unsigned CB_IE = 7;
    localparam int unsigned CB_PE = 6;
    localparam int unsigned CB_DIV = 5;
    localparam int unsigned CB_MS = 4;
    localparam int unsigned CB_CLOCK_IDLE_LEVEL = 3;
    localparam int unsigned CB_CAPTURE_EDGE_SELECT = 2;
    localparam int unsigned CB_R1 = 1;
    localparam int unsigned CB_R0 = 0;
    localparam logic [DATA_W-1:0] PE_MS_MASK = 8'h50;

    // Status register fields
    localparam int unsigned SB_TDF = 7;
    localparam int unsigned SB_WRITE_COLLISION_FLAG = 6;
    localparam int unsigned SB_MF = 4;

    localparam logic [DATA_W-1:0] CTRL_RST = 8'h00;
    localparam logic [DATA_W-1:0] DATA_RST = 8'h00;
    localparam logic [3:0] PIN_IN_RST = 4'h1;

    // Sixteen clock edges per byte
    localparam logic [3:0] LAST_EDGE = 4'hF;

    // Divider: half period minus one, in cpu clocks
    localparam int unsigned HALF_W = 6;
    localparam logic [HALF_W-1:0] HALF_DIV4 = 6'h01;
    localparam logic [HALF_W-1:0] HALF_DIV8 = 6'h03;
    localparam logic [HALF_W-1:0] HALF_DIV16 = 6'h07;
    localparam logic [HALF_W-1:0] HALF_DIV32 = 6'h0F;
    localparam logic [HALF_W-1:0] HALF_DIV64 = 6'h1F;
    localparam logic [HALF_W-1:0] HALF_DIV128 = 6'h3F;
    localparam logic [2:0] RATE_DIV4 = 3'h4;
    localparam logic [2:0] RATE_DIV8 = 3'h0;
    localparam logic [2:0] RATE_DIV16 = 3'h1;
    localparam logic [2:0] RATE_DIV32 = 3'h6;
    localparam logic [2:0] RATE_DIV64 = 3'h2;
    localparam logic [2:0] RATE_DIV128 = 3'h3;

    typedef enum logic [0:0] {ST_IDLE = 1'h0, ST_SHIFT = 1'h1} spmsp_state_t;

    typedef struct packed {
        logic sck;
        logic mosi;
        logic miso;
        logic ss_n;
    } spmsp_pin_in_t;

    typedef struct packed {
        logic sck;
        logic sck_oe_n;
        logic mosi;
        logic mosi_oe_n;
        logic miso;
        logic miso_oe_n;
    } spmsp_pin_out_t;

    function automatic logic [HALF_W-1:0] spmsp_half_period(input logic [2:0] rate);
        logic [HALF_W-1:0] h;
        h = HALF_DIV4;
        case (rate)
            RATE_DIV4: h = HALF_DIV4;
            RATE_DIV8: h = HALF_DIV8;
            RATE_DIV16: h = HALF_DIV16;
            RATE_DIV32: h = HALF_DIV32;
            RATE_DIV64: h = HALF_DIV64;
            RATE_DIV128: h = HALF_DIV128;
            default: h = rate[1] ? HALF_DIV32 : HALF_DIV4;
        endcase
        return h;
    endfunction

endpackage

// ===== rtl/spmsp_clkdiv.sv
// Master serial clock divider: one tick per half period while running
module spmsp_clkdiv #(
    parameter int unsigned HALF_W = 6
) (
    input wire logic clk_i,
    input wire logic rst_n_i,
    input wire logic run_i,
    input wire logic [HALF_W-1:0] half_i,
    output logic tick_o
);
    logic [HALF_W-1:0] cnt;
    logic [HALF_W-1:0] next_cnt;

    assign tick_o = run_i & (cnt == half_i);
    assign next_cnt = (!run_i || tick_o) ? '0 : cnt + 1'h1;

    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            cnt <= '0;
        end else begin
            cnt <= next_cnt;
        end
    end

endmodule

// ===== rtl/spmsp_port.sv
// Byte-wide serial port, master or slave, with control, status and data registers
//
// Summary of operation
// - Unread slave bytes: buffer keeps first, no overrun.
// - Wait state: runs on, enabled events wake.
// - Halt state: port frozen, registers hold values.
// - Interrupt enable gates done and fault flags.
// - Port enable routes pins; reset, fault clear it.
// - Master bit drives clock, swaps data pins.
// - Polarity bit sets serial clock idle level.
// - Phase bit picks first or second capture edge.
// - Master clock divided by three rate bits.
// - Slave ignores rate bits, uses external clock.
// - Done flag: set at end, status-then-data clears.
// - Data writes ignored while done flag set.
// - Write during transfer: collision flag, write dropped.
// - Select low in master: fault flag, special clear.
// - Only data write starts a master transfer.
// - Last cycle copies received byte to read buffer.
// - Accepted data write loads shift register directly.
// - One request line, enable and cpu mask gate.
// - Eight bits, MSB first, full duplex.
// - Slave phase 0: select low freezes data.
// - Fault flag blocks setting enable and master bits.
module spmsp_port (
    input wire logic clk_i,
    input wire logic nrst_i,
    input wire logic [spmsp_pkg::ADDR_W-1:0] addr_i,
    input wire logic [spmsp_pkg::DATA_W-1:0] wdata_i,
    input wire logic wr_i,
    input wire logic rd_i,
    output logic [spmsp_pkg::DATA_W-1:0] rdata_o,
    input wire spmsp_pkg::spmsp_pin_in_t pin_i,
    output spmsp_pkg::spmsp_pin_out_t pin_o,
    input wire logic irq_mask_i,
    input wire logic wait_i,
    input wire logic halt_i,
    output logic irq_o,
    output logic wake_o
);
    import spmsp_pkg::*;

    function automatic logic hit(input logic [ADDR_W-1:0] a, input logic [ADDR_W-1:0] off);
        return a == off;
    endfunction

    // Reset release
    logic rst_meta;
    logic rst_n;

    always_ff @(posedge clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            rst_meta <= 1'h0;
            rst_n <= 1'h0;
        end else begin
            rst_meta <= 1'h1;
            rst_n <= rst_meta;
        end
    end

    // Pin synchronisers
    spmsp_pin_in_t pin_m;
    spmsp_pin_in_t pin_s;
    logic sck_d;

    always_ff @(posedge clk_i or negedge rst_n) begin
        if (!rst_n) begin
            pin_m <= PIN_IN_RST;
            pin_s <= PIN_IN_RST;
            sck_d <= 1'h0;
        end else begin
            pin_m <= pin_i;
            pin_s <= pin_m;
            sck_d <= pin_s.sck;
        end
    end

    // State
    logic [DATA_W-1:0] ctrl;
    logic [DATA_W-1:0] shreg;
    logic [DATA_W-1:0] rxbuf;
    logic [3:0] edge_cnt;
    logic out_bit;
    logic sck_int;
    logic m_edge;
    logic tdf;
    logic tdf_arm;
    logic write_collision_flag;
    logic write_collision_flag_arm;
    logic mf;
    logic mf_arm;
    spmsp_state_t state;
    spmsp_state_t next_state;

    // Halt freezes register, flag and shift updates; the divider count clears to zero
    wire live = ~halt_i;

    // Bus decode
    wire acc_data_rd = rd_i & live & hit(addr_i, OFF_DATA);
    wire acc_data_wr = wr_i & live & hit(addr_i, OFF_DATA);
    wire acc_data = acc_data_rd | acc_data_wr;
    wire acc_ctrl_wr = wr_i & live & hit(addr_i, OFF_CTRL);
    wire acc_stat = (rd_i | wr_i) & live & hit(addr_i, OFF_STAT);

    // Control fields
    wire ie = ctrl[CB_IE];
    wire pe = ctrl[CB_PE];
    wire clock_idle_level = ctrl[CB_CLOCK_IDLE_LEVEL];
    wire capture_edge_select = ctrl[CB_CAPTURE_EDGE_SELECT];
    wire [2:0] rate = {ctrl[CB_DIV], ctrl[CB_R1], ctrl[CB_R0]};

    // Mode
    wire master = pe & ctrl[CB_MS];
    wire slave_act = pe & ~ctrl[CB_MS] & ~pin_s.ss_n;
    wire fault = master & ~pin_s.ss_n & live;

    // Edge sources
    // Internal master edge lags the divider tick by one clock, in the same cycle as the pin change
    wire m_tick;
    wire s_edge = slave_act & (pin_s.sck ^ sck_d) & live;
    wire edge_ev = (m_edge & master & live) | s_edge;
    wire sample = edge_ev & (edge_cnt[0] == capture_edge_select);
    wire last = edge_ev & (edge_cnt == LAST_EDGE);
    wire din = master ? pin_s.miso : pin_s.mosi;
    wire [DATA_W-1:0] rx_word = sample ? {shreg[DATA_W-2:0], din} : shreg;

    spmsp_clkdiv #(
        .HALF_W(HALF_W)
    ) u_div (
        .clk_i(clk_i),
        .rst_n_i(rst_n),
        .run_i((state == ST_SHIFT) & master & live),
        .half_i(spmsp_half_period(rate)),
        .tick_o(m_tick)
    );

    // Transfer in progress, as seen by a data write
    wire busy = master ? (state == ST_SHIFT)
                       : (slave_act & (~capture_edge_select | (edge_cnt != 4'h0)));

    wire dr_ok = acc_data_wr & ~tdf & ~busy;
    wire write_collision_flag_set = acc_data_wr & ~tdf & busy;
    wire start = dr_ok & master & ~fault & (state == ST_IDLE);

    // Flag clear sequences
    wire tdf_clr = tdf_arm & acc_data;
    wire write_collision_flag_clr = write_collision_flag_arm & acc_data;
    wire mf_clr = mf_arm & acc_ctrl_wr;

    // Enable and master bits locked while the fault is pending
    wire mf_lock = mf & ~mf_arm;
    wire [DATA_W-1:0] lock_mask = mf_lock ? ~PE_MS_MASK : 8'hFF;
    wire [DATA_W-1:0] ctrl_wr_val = wdata_i & (lock_mask | ctrl);

    wire [DATA_W-1:0] next_ctrl = fault ? (ctrl & ~PE_MS_MASK)
                                : acc_ctrl_wr ? ctrl_wr_val : ctrl;

    wire next_tdf = last | (tdf & ~tdf_clr);
    wire next_write_collision_flag = write_collision_flag_set | (write_collision_flag & ~write_collision_flag_clr);
    wire next_mf = fault | (mf & ~mf_clr);

    // Status image, unused bits zero
    wire [DATA_W-1:0] stat_val = {tdf, write_collision_flag, 1'h0, mf, 4'h0};

    wire [DATA_W-1:0] rd_mux = hit(addr_i, OFF_DATA) ? rxbuf
                             : hit(addr_i, OFF_CTRL) ? ctrl
                             : hit(addr_i, OFF_STAT) ? stat_val
                             : 8'h00;

    always_comb begin
        next_state = ST_IDLE;
        case (state)
            ST_IDLE: begin
                next_state = start ? ST_SHIFT : ST_IDLE;
            end
            ST_SHIFT: begin
                if (!master || last || fault) begin
                    next_state = ST_IDLE;
                end else begin
                    next_state = ST_SHIFT;
                end
            end
            default: begin
                next_state = ST_IDLE;
            end
        endcase
    end

    // Registers and flags
    always_ff @(posedge clk_i or negedge rst_n) begin
        if (!rst_n) begin
            state <= ST_IDLE;
            m_edge <= 1'h0;
            ctrl <= CTRL_RST;
            tdf <= 1'h0;
            write_collision_flag <= 1'h0;
            mf <= 1'h0;
            tdf_arm <= 1'h0;
            write_collision_flag_arm <= 1'h0;
            mf_arm <= 1'h0;
        end else if (live) begin
            state <= next_state;
            m_edge <= m_tick;
            ctrl <= next_ctrl;
            tdf <= next_tdf;
            write_collision_flag <= next_write_collision_flag;
            mf <= next_mf;
            tdf_arm <= tdf & (tdf_arm | acc_stat) & ~acc_data;
            write_collision_flag_arm <= write_collision_flag & (write_collision_flag_arm | acc_stat) & ~acc_data;
            mf_arm <= mf & (mf_arm | acc_stat) & ~acc_ctrl_wr;
        end
    end

    // Edge counter, restarted per byte
    always_ff @(posedge clk_i or negedge rst_n) begin
        if (!rst_n) begin
            edge_cnt <= 4'h0;
        end else if (start || !pe || (!ctrl[CB_MS] && pin_s.ss_n)) begin
            edge_cnt <= 4'h0;
        end else if (edge_ev) begin
            edge_cnt <= edge_cnt + 4'h1;
        end
    end

    // Shift register, MSB first, loaded straight from the bus
    always_ff @(posedge clk_i or negedge rst_n) begin
        if (!rst_n) begin
            shreg <= DATA_RST;
            out_bit <= 1'h0;
        end else if (dr_ok) begin
            shreg <= wdata_i;
            out_bit <= wdata_i[DATA_W-1];
        end else if (sample) begin
            shreg <= rx_word;
        end else if (edge_ev) begin
            out_bit <= shreg[DATA_W-1];
        end
    end

    // Receive buffer keeps the first byte after a clear
    always_ff @(posedge clk_i or negedge rst_n) begin
        if (!rst_n) begin
            rxbuf <= DATA_RST;
        end else if (last && (!tdf || tdf_clr)) begin
            rxbuf <= rx_word;
        end
    end

    // Master serial clock phase
    always_ff @(posedge clk_i or negedge rst_n) begin
        if (!rst_n) begin
            sck_int <= 1'h0;
        end else if (state == ST_IDLE) begin
            sck_int <= 1'h0;
        end else if (m_tick) begin
            sck_int <= ~sck_int;
        end
    end

    // Read data, valid the cycle after the strobe
    always_ff @(posedge clk_i or negedge rst_n) begin
        if (!rst_n) begin
            rdata_o <= 8'h00;
        end else begin
            rdata_o <= rd_i ? rd_mux : 8'h00;
        end
    end

    // Pins; enables low while driving, all released when disabled
    assign pin_o.sck = clock_idle_level ^ sck_int;
    assign pin_o.sck_oe_n = ~master;
    assign pin_o.mosi = out_bit;
    assign pin_o.mosi_oe_n = ~master;
    assign pin_o.miso = out_bit;
    assign pin_o.miso_oe_n = ~slave_act;

    // Shared request line and wake-up
    assign irq_o = ie & (tdf | mf) & ~irq_mask_i;
    assign wake_o = wait_i & irq_o;

    // Checks

    property p_rx_read;
        @(posedge clk_i) disable iff (!rst_n)
        acc_data_rd |=> rdata_o == $past(rxbuf);
    endproperty
    a_rx_read: assert property (p_rx_read) else $error("data read missed buffer");

    property p_keep_first;
        @(posedge clk_i) disable iff (!rst_n)
        last && tdf && !tdf_clr |=> $stable(rxbuf);
    endproperty
    a_keep_first: assert property (p_keep_first) else $error("buffer overwritten");

    property p_halt_hold;
        @(posedge clk_i) disable iff (!rst_n)
        halt_i |=> $stable(ctrl) && $stable(tdf) && $stable(mf) && $stable(shreg);
    endproperty
    a_halt_hold: assert property (p_halt_hold) else $error("state moved in halt");

    property p_wake;
        @(posedge clk_i) disable iff (!rst_n)
        wait_i && ie && tdf && !irq_mask_i |-> wake_o;
    endproperty
    a_wake: assert property (p_wake) else $error("no wake from wait");

    property p_irq_on;
        @(posedge clk_i) disable iff (!rst_n)
        ie && (tdf || mf) && !irq_mask_i |-> irq_o;
    endproperty
    a_irq_on: assert property (p_irq_on) else $error("interrupt not raised");

    property p_irq_mask;
        @(posedge clk_i) disable iff (!rst_n)
        irq_mask_i || !ie |-> !irq_o;
    endproperty
    a_irq_mask: assert property (p_irq_mask) else $error("masked interrupt seen");

    property p_ignore_wr;
        @(posedge clk_i) disable iff (!rst_n)
        acc_data_wr && tdf && !edge_ev |=> $stable(shreg);
    endproperty
    a_ignore_wr: assert property (p_ignore_wr) else $error("write taken while done");

    property p_collide;
        @(posedge clk_i) disable iff (!rst_n)
        acc_data_wr && !tdf && busy |=> write_collision_flag && !$past(dr_ok);
    endproperty
    a_collide: assert property (p_collide) else $error("collision not flagged");

    property p_fault;
        @(posedge clk_i) disable iff (!rst_n)
        fault |=> mf && !ctrl[CB_PE] && !ctrl[CB_MS] && state == ST_IDLE;
    endproperty
    a_fault: assert property (p_fault) else $error("fault not handled");

    property p_start;
        @(posedge clk_i) disable iff (!rst_n)
        state == ST_IDLE ##1 state == ST_SHIFT |-> $past(acc_data_wr);
    endproperty
    a_start: assert property (p_start) else $error("transfer without write");

    property p_load;
        @(posedge clk_i) disable iff (!rst_n)
        dr_ok |=> shreg == $past(wdata_i);
    endproperty
    a_load: assert property (p_load) else $error("shift register not loaded");

    property p_sck_idle;
        @(posedge clk_i) disable iff (!rst_n)
        master && state == ST_IDLE |-> pin_o.sck == clock_idle_level && !pin_o.sck_oe_n;
    endproperty
    a_sck_idle: assert property (p_sck_idle) else $error("clock idle level wrong");

    property p_div4;
        @(posedge clk_i) disable iff (!rst_n)
        m_edge && rate == RATE_DIV4 && !last ##1 master && live [*2] |-> m_edge;
    endproperty
    a_div4: assert property (p_div4) else $error("divide by four wrong");

endmodule

// ===== test/spmsp_peer.sv
// External serial slave model facing the port in master mode
module spmsp_peer (
    input wire logic clk_i,
    input wire logic sel_i,
    input wire logic capture_edge_select_i,
    input wire logic load_i,
    input wire logic [7:0] tx_i,
    input wire logic sck_i,
    input wire logic mosi_i,
    output logic miso_o,
    output logic miso_en_o,
    output logic [7:0] rx_o
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [7:0] shift = 8'h00;
    logic [3:0] edge_idx = 4'h0;
    logic sck_q = 1'b0;
    logic sck_edge;
    logic out_edge;
    initial rx_o = 8'h00;
    assign sck_edge = sel_i && (sck_i != sck_q);
    // Drive side shifts on the non-capture edges, never before the first capture
    assign out_edge = sck_edge && (edge_idx[0] != capture_edge_select_i) && (edge_idx != 4'h0);
    always @(posedge clk_i) begin
        sck_q <= sck_i;
        if (load_i) begin
            shift <= tx_i;
            edge_idx <= 4'h0;
        end else if (sck_edge) begin
            edge_idx <= edge_idx + 4'h1;
            if (edge_idx[0] == capture_edge_select_i) begin
                rx_o <= {rx_o[6:0], mosi_i};
            end else if (out_edge) begin
                shift <= {shift[6:0], 1'b0};
            end
        end
    end
    // Next bit shows in the same cycle as the clock change
    assign miso_o = out_edge ? shift[6] : shift[7];
    assign miso_en_o = sel_i;
endmodule

// ===== test/testbench.sv
// Self-checking bench for the serial port with an external slave model
`define CHK(what, exp, got) begin total_checks++; if ((got) !== (exp)) begin miscompares++; \
    $display("mismatch %s exp %h got %h", what, exp, got); end end
module testbench;
    timeunit 1ns;
    timeprecision 1ps;
    import spmsp_pkg::*;
    logic clk_i = 1'b0;
    logic nrst_i = 1'b0;
    logic [ADDR_W-1:0] addr_i = '0;
    logic [DATA_W-1:0] wdata_i = '0;
    logic [DATA_W-1:0] rdata_o;
    logic wr_i = 1'b0;
    logic rd_i = 1'b0;
    logic irq_mask_i = 1'b0;
    logic wait_i = 1'b0;
    logic halt_i = 1'b0;
    logic irq_o;
    logic wake_o;
    spmsp_pin_in_t pin_i;
    spmsp_pin_out_t pin_o;
    logic ss_n = 1'b1;
    logic junk = 1'b0;
    logic peer_sel = 1'b0;
    logic peer_capture_edge_select = 1'b0;
    logic peer_load = 1'b0;
    logic [7:0] peer_tx = 8'h00;
    logic peer_miso;
    logic peer_en;
    logic [7:0] peer_rx;
    logic sck_w;
    logic mosi_w;
    logic miso_w;
    int miscompares = 0;
    int total_checks = 0;
    logic [2:0] rates [6] = '{RATE_DIV4, RATE_DIV8, RATE_DIV16, RATE_DIV32, RATE_DIV64,
        RATE_DIV128};

    // Undriven data lines toggle so a stale value never passes; undriven clock reads low
    assign sck_w = pin_o.sck_oe_n ? 1'b0 : pin_o.sck;
    assign mosi_w = pin_o.mosi_oe_n ? junk : pin_o.mosi;
    assign miso_w = !pin_o.miso_oe_n ? pin_o.miso : (peer_en ? peer_miso : junk);
    assign pin_i = {sck_w, mosi_w, miso_w, ss_n};

    spmsp_port dut_u (.clk_i(clk_i), .nrst_i(nrst_i), .addr_i(addr_i), .wdata_i(wdata_i),
        .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o), .pin_i(pin_i), .pin_o(pin_o),
        .irq_mask_i(irq_mask_i), .wait_i(wait_i), .halt_i(halt_i), .irq_o(irq_o),
        .wake_o(wake_o));
    spmsp_peer peer_u (.clk_i(clk_i), .sel_i(peer_sel), .capture_edge_select_i(peer_capture_edge_select),
        .load_i(peer_load), .tx_i(peer_tx), .sck_i(sck_w), .mosi_i(mosi_w),
        .miso_o(peer_miso), .miso_en_o(peer_en), .rx_o(peer_rx));

    initial begin
        forever #20 clk_i = ~clk_i;
    end
    always @(posedge clk_i) junk <= ~junk;

    task automatic bus_wr(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d);
        @(posedge clk_i);
        wr_i <= 1'b1;
        addr_i <= a;
        wdata_i <= d;
        @(posedge clk_i);
        wr_i <= 1'b0;
    endtask

    task automatic rd_chk(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] e,
        input string what);
        @(posedge clk_i);
        rd_i <= 1'b1;
        addr_i <= a;
        @(posedge clk_i);
        rd_i <= 1'b0;
        @(negedge clk_i);
        `CHK(what, e, rdata_o)
    endtask

    task automatic peer_arm(input logic capture_edge_select, input logic [7:0] tx);
        peer_capture_edge_select <= capture_edge_select;
        peer_tx <= tx;
        peer_sel <= 1'b1;
        peer_load <= 1'b1;
        @(posedge clk_i);
        peer_load <= 1'b0;
    endtask

    task automatic wait_irq();
        int n;
        n = 0;
        while (irq_o !== 1'b1 && n < 3000) begin
            @(negedge clk_i);
            n++;
        end
        `CHK("irq_o", 1'b1, irq_o)
    endtask

    task automatic t_reset();
        rd_chk(OFF_CTRL, CTRL_RST, "control");
        rd_chk(OFF_STAT, 8'h00, "status");
        rd_chk(OFF_DATA, DATA_RST, "data");
        bus_wr(2'h3, 8'hFF);
        rd_chk(2'h3, 8'h00, "unmapped");
        bus_wr(OFF_STAT, 8'hFF);
        rd_chk(OFF_STAT, 8'h00, "status after write");
        $display("test reset done");
    endtask

    task automatic t_xfer(input logic [2:0] rate, input int half, input logic clock_idle_level,
        input logic capture_edge_select, input logic [7:0] tx, input logic [7:0] rx);
        int n;
        bus_wr(OFF_CTRL, {2'b11, rate[2], 1'b1, clock_idle_level, capture_edge_select, rate[1:0]});
        peer_arm(capture_edge_select, rx);
        @(negedge clk_i);
        `CHK("idle clock", clock_idle_level, pin_o.sck)
        `CHK("clock enable", 1'b0, pin_o.sck_oe_n)
        `CHK("miso enable", 1'b1, pin_o.miso_oe_n)
        bus_wr(OFF_DATA, tx);
        n = 0;
        while (pin_o.sck === clock_idle_level && n < 200) begin
            @(negedge clk_i);
            n++;
        end
        n = 0;
        while (pin_o.sck !== clock_idle_level && n < 200) begin
            @(negedge clk_i);
            n++;
        end
        `CHK("half period", half, n)
        wait_irq();
        `CHK("peer rx", tx, peer_rx)
        rd_chk(OFF_STAT, 8'h80, "done flag");
        rd_chk(OFF_DATA, rx, "received");
        rd_chk(OFF_STAT, 8'h00, "done cleared");
        peer_sel <= 1'b0;
        $display("test transfer rate %0d done", rate);
    endtask

    task automatic t_collide();
        int n;
        bus_wr(OFF_CTRL, 8'hD1);
        peer_arm(1'b0, 8'h5A);
        bus_wr(OFF_DATA, 8'h96);
        repeat (8) @(posedge clk_i);
        bus_wr(OFF_DATA, 8'h0F);
        wait_irq();
        `CHK("peer rx", 8'h96, peer_rx)
        bus_wr(OFF_DATA, 8'h33);
        n = 0;
        repeat (40) begin
            @(negedge clk_i);
            if (pin_o.sck !== 1'b0) n++;
        end
        `CHK("no new transfer", 0, n)
        @(posedge clk_i);
        irq_mask_i <= 1'b1;
        @(negedge clk_i);
        `CHK("masked irq", 1'b0, irq_o)
        @(posedge clk_i);
        irq_mask_i <= 1'b0;
        wait_i <= 1'b1;
        @(negedge clk_i);
        `CHK("wake", 1'b1, wake_o)
        @(posedge clk_i);
        wait_i <= 1'b0;
        rd_chk(OFF_STAT, 8'hC0, "collision flag");
        rd_chk(OFF_DATA, 8'h5A, "received");
        rd_chk(OFF_STAT, 8'h00, "flags cleared");
        peer_sel <= 1'b0;
        $display("test collision done");
    endtask

    task automatic t_fault();
        bus_wr(OFF_CTRL, 8'hD0);
        @(posedge clk_i);
        ss_n <= 1'b0;
        repeat (6) @(posedge clk_i);
        ss_n <= 1'b1;
        @(negedge clk_i);
        `CHK("fault irq", 1'b1, irq_o)
        rd_chk(OFF_CTRL, 8'h80, "control after fault");
        bus_wr(OFF_CTRL, 8'hD0);
        rd_chk(OFF_CTRL, 8'h80, "refused enable");
        rd_chk(OFF_STAT, 8'h10, "fault flag");
        bus_wr(OFF_CTRL, 8'h50);
        rd_chk(OFF_STAT, 8'h00, "fault cleared");
        rd_chk(OFF_CTRL, 8'h50, "enable restored");
        @(negedge clk_i);
        `CHK("irq off", 1'b0, irq_o)
        $display("test fault done");
    endtask

    task automatic t_halt();
        @(posedge clk_i);
        halt_i <= 1'b1;
        bus_wr(OFF_CTRL, 8'h0C);
        @(posedge clk_i);
        halt_i <= 1'b0;
        rd_chk(OFF_CTRL, 8'h50, "held in halt");
        $display("test halt done");
    endtask

    task automatic t_slave();
        bus_wr(OFF_CTRL, 8'h40);
        @(negedge clk_i);
        `CHK("slave clock enable", 1'b1, pin_o.sck_oe_n)
        `CHK("slave mosi enable", 1'b1, pin_o.mosi_oe_n)
        bus_wr(OFF_DATA, 8'hC3);
        @(posedge clk_i);
        ss_n <= 1'b0;
        repeat (4) @(negedge clk_i);
        `CHK("slave miso enable", 1'b0, pin_o.miso_oe_n)
        `CHK("slave miso", 1'b1, pin_o.miso)
        bus_wr(OFF_DATA, 8'h55);
        rd_chk(OFF_STAT, 8'h40, "slave collision");
        @(posedge clk_i);
        ss_n <= 1'b1;
        $display("test slave done");
    endtask

    task automatic complete_run();
        $display("checks %0d mismatches %0d", total_checks, miscompares);
        if (miscompares == 0 && total_checks > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask

    initial begin
        repeat (60000) @(posedge clk_i);
        miscompares++;
        complete_run();
    end

    initial begin
        repeat (16) @(posedge clk_i);
        nrst_i <= 1'b1;
        repeat (3) @(posedge clk_i);
        t_reset();
        for (int i = 0; i < 6; i++) begin
            t_xfer(rates[i], 2 << i, i[0], i[1], 8'hA5 ^ i[7:0], 8'h3C + i[7:0]);
        end
        t_collide();
        t_fault();
        t_halt();
        t_slave();
        complete_run();
    end
endmodule
